// >>> design/dac_cmd_pkg.sv
// package: command codes, field positions, reset values for the octal dac command decoder
package dac_cmd_pkg;
  localparam int  CHANNELS       = 8;
  localparam int  CODE_W         = 10;
  localparam int  FRAME_W        = 16;
  localparam int  MIN_EDGES      = 15;
  localparam int  CNT_W          = 5;
  localparam int  NIB_HI         = 15;
  localparam int  NIB_LO         = 12;
  localparam int  CODE_HI        = 11;
  localparam int  CODE_LO        = 2;
  localparam int  ADDR_HI        = 14;
  localparam int  ADDR_LO        = 12;
  localparam int  MASK_HI        = 7;
  localparam int  MASK_LO        = 0;
  localparam logic [3:0] CMD_REG_ONLY   = 4'h8;
  localparam logic [3:0] CMD_WRITE_THRU = 4'h9;
  localparam logic [3:0] CMD_UPDATE_SEL = 4'hA;
  localparam logic [3:0] CMD_CHA_WRITE  = 4'hB;
  localparam logic [3:0] CMD_BROADCAST  = 4'hC;
  localparam logic [3:0] CMD_PD_HIZ     = 4'hD;
  localparam logic [3:0] CMD_PD_100K    = 4'hE;
  localparam logic [3:0] CMD_PD_2K5     = 4'hF;
  localparam logic [9:0] CODE_RESET     = 10'h000;

  typedef enum logic [1:0] {
    TERM_HIZ  = 2'h0,
    TERM_100K = 2'h1,
    TERM_2K5  = 2'h2
  } term_t;
  localparam term_t TERM_RESET = TERM_HIZ;
endpackage

// >>> design/frame_capture.sv
// module: serial shift register on the link clock, frames words and hands them over by toggle
`timescale 1ns/1ps
module frame_capture (
  // link pins
  input  wire logic       link_clk,
  input  wire logic       frame_sel_n,
  input  wire logic       serial_data,
  // hand-over
  frame_if.link           frame
);
  import dac_cmd_pkg::*;

  // power-up values: the link side has no reset, and a count left unknown would lose the first frame
  logic [FRAME_W-1:0] shift;
  logic [CNT_W-1:0]   edges = '0;
  logic [FRAME_W-1:0] word_hold;
  logic               toggle = 1'b0;

  // ----------------------------------------
  // shift on falling edges while framed
  // ----------------------------------------
  // the count is cleared asynchronously by frame select: the link clock stops between frames,
  // so the frame's own rising edge must end it
  always_ff @(negedge link_clk or posedge frame_sel_n) begin
    if (frame_sel_n) begin
      edges <= '0;
    end else if (edges != 5'h1F) begin
      edges <= edges + 5'h01;
    end
  end

  always_ff @(negedge link_clk) begin
    if (!frame_sel_n) begin
      shift <= {shift[FRAME_W-2:0], serial_data};
    end
  end

  // ----------------------------------------
  // completion on frame select rising
  // ----------------------------------------
  // short frames never toggle, so nothing is executed
  always_ff @(posedge frame_sel_n) begin
    if (edges >= CNT_W'(MIN_EDGES)) begin
      word_hold <= shift;
      toggle    <= ~toggle;
    end
  end

  assign frame.word   = word_hold;
  assign frame.toggle = toggle;
endmodule

// >>> design/frame_if.sv
// interface: captured frame handed from the link domain to the system domain
`timescale 1ns/1ps
interface frame_if;
  logic [15:0] word;
  logic        toggle;
  modport link (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// >>> design/octal_dac_command_decoder.sv
// module: command decoder of an eight channel 10-bit dac behind a three wire serial link
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module octal_dac_command_decoder #(
  parameter int CHANNELS = dac_cmd_pkg::CHANNELS,
  parameter int CODE_W   = dac_cmd_pkg::CODE_W
) (
  // system
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // serial link, clocked by the host
  input  wire logic                     link_clk,
  input  wire logic                     frame_sel_n,
  input  wire logic                     serial_data,
  // analog control outputs
  output logic [CHANNELS*CODE_W-1:0]    dac_output,
  output logic [CHANNELS*CODE_W-1:0]    data_register,
  output logic [CHANNELS-1:0]           channel_power_down,
  output logic [CHANNELS*2-1:0]         channel_termination,
  output logic                          bias_enable,
  // status
  output logic                          write_through_mode,
  output logic                          frame_done
);
  import dac_cmd_pkg::*;

  frame_if frame ();

  frame_capture u_capture (
    .link_clk    (link_clk),
    .frame_sel_n (frame_sel_n),
    .serial_data (serial_data),
    .frame       (frame)
  );

  // ----------------------------------------
  // crossing: toggle through two flops, word copied after the synchronised edge
  // ----------------------------------------
  // no reset on the chain: it keeps sampling through reset, so a toggle left over from before
  // a reset is absorbed there and never replays the last frame; reset must last three clocks
  logic        tog_meta;
  logic        tog_sync;
  logic        tog_seen;
  logic        new_frame;
  logic        exec;
  logic [15:0] cmd_word;

  always_ff @(posedge sys_clk) begin
    tog_meta <= frame.toggle;
    tog_sync <= tog_meta;
  end

  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  // one frame per pass: copy the word, execute for one clock, report; a toggle that arrives
  // while busy waits in the synchroniser, but frames closer than the pass share one word
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_EXEC = 3'b010,
    SEQ_DONE = 3'b100
  } seq_t;

  seq_t seq_state;

  assign new_frame = (seq_state == SEQ_IDLE) && (tog_sync != tog_seen);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seq_state <= SEQ_IDLE;
    end else begin
      unique case (seq_state)
        SEQ_IDLE: begin
          if (new_frame) begin
            seq_state <= SEQ_EXEC;
          end
        end
        SEQ_EXEC: seq_state <= SEQ_DONE;
        SEQ_DONE: seq_state <= SEQ_IDLE;
        default:  seq_state <= SEQ_IDLE;
      endcase
    end
  end

  // the seen copy only moves while idle or in reset, so no toggle is lost during a pass
  always_ff @(posedge sys_clk) begin
    if (reset || seq_state == SEQ_IDLE) begin
      tog_seen <= tog_sync;
    end
  end

  // the word has stood since before the first synchroniser flop saw the toggle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_word <= 16'h0000;
    end else if (new_frame) begin
      cmd_word <= frame.word;
    end
  end

  assign exec = (seq_state == SEQ_EXEC);

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [3:0]          command_nibble;
  logic [11:0]         payload_field;
  logic [7:0]          channel_select_mask;
  logic [2:0]          channel_address_field;
  logic [CODE_W-1:0]   new_code;
  logic                is_chan_write;
  logic [CHANNELS-1:0] reg_load;
  logic [CHANNELS-1:0] out_load;
  logic [CHANNELS-1:0] pd_set;
  logic                register_only_mode;

  assign command_nibble        = cmd_word[NIB_HI:NIB_LO];
  assign payload_field         = cmd_word[CODE_HI:0];
  assign channel_select_mask   = cmd_word[MASK_HI:MASK_LO];
  assign channel_address_field = cmd_word[ADDR_HI:ADDR_LO];
  assign new_code              = cmd_word[CODE_HI:CODE_LO];
  assign is_chan_write         = ~cmd_word[NIB_HI];
  assign register_only_mode    = ~write_through_mode;

  logic unused_bits;
  assign unused_bits = ^{payload_field, register_only_mode};

  // ----------------------------------------
  // mode commands, true only in the execute clock
  // ----------------------------------------
  logic is_reg_only;
  logic is_write_thru;

  assign is_reg_only   = exec && (command_nibble == CMD_REG_ONLY);
  assign is_write_thru = exec && (command_nibble == CMD_WRITE_THRU);

  // per-channel load decisions for one executed frame
  always_comb begin
    reg_load = '0;
    out_load = '0;
    pd_set   = '0;
    if (exec) begin
      if (is_chan_write) begin
        reg_load[channel_address_field] = 1'b1;
        out_load[channel_address_field] = write_through_mode;
      end else begin
        // special commands ignore the mode
        unique case (command_nibble)
          CMD_UPDATE_SEL: out_load = channel_select_mask[CHANNELS-1:0];
          CMD_CHA_WRITE: begin
            reg_load[0] = 1'b1;
            out_load    = '1;
          end
          CMD_BROADCAST: begin
            reg_load = '1;
            out_load = '1;
          end
          CMD_PD_HIZ, CMD_PD_100K, CMD_PD_2K5: pd_set = channel_select_mask[CHANNELS-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      write_through_mode <= 1'b0;
    end else if (is_write_thru) begin
      write_through_mode <= 1'b1;
    end else if (is_reg_only) begin
      write_through_mode <= 1'b0;
    end
    // channel-A-write and others leave the mode alone
  end

  // ----------------------------------------
  // termination selected by the power-down nibble
  // ----------------------------------------
  term_t new_term;
  always_comb begin
    unique case (command_nibble)
      CMD_PD_100K: new_term = TERM_100K;
      CMD_PD_2K5:  new_term = TERM_2K5;
      default:     new_term = TERM_HIZ;
    endcase
  end

  // ----------------------------------------
  // per-channel state
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          data_register[ch*CODE_W +: CODE_W] <= CODE_RESET;
        end else if (reg_load[ch]) begin
          // power-down never touches this register
          data_register[ch*CODE_W +: CODE_W] <= new_code;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          dac_output[ch*CODE_W +: CODE_W] <= CODE_RESET;
        end else if (out_load[ch]) begin
          // a register written in the same frame feeds its output directly
          dac_output[ch*CODE_W +: CODE_W] <= reg_load[ch] ? new_code : data_register[ch*CODE_W +: CODE_W];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          channel_power_down[ch] <= 1'b0;
        end else if (pd_set[ch]) begin
          channel_power_down[ch] <= 1'b1;
        end else if (out_load[ch]) begin
          channel_power_down[ch] <= 1'b0;
        end
      end

      // kept after wake-up; it only matters while the channel is powered down
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          channel_termination[ch*2 +: 2] <= TERM_RESET;
        end else if (pd_set[ch]) begin
          channel_termination[ch*2 +: 2] <= new_term;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // shared bias and status
  // ----------------------------------------
  // one clock behind the flags, so the bias never drops while a wake is in flight
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bias_enable <= 1'b1;
    end else begin
      bias_enable <= ~(&channel_power_down);
    end
  end

  // high in the clock in which the new outputs other than the bias, and the new mode, are first visible
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_done <= 1'b0;
    end else begin
      frame_done <= exec;
    end
  end
endmodule

// >>> verif/dac_cmd_properties.sv
// checker: port timing of the dac command decoder
`timescale 1ns/1ps
module dac_cmd_properties #(
  parameter int CHANNELS = dac_cmd_pkg::CHANNELS,
  parameter int CODE_W   = dac_cmd_pkg::CODE_W
) (
  // system and link
  input wire logic                       sys_clk,
  input wire logic                       reset,
  input wire logic                       link_clk,
  input wire logic                       frame_sel_n,
  input wire logic                       serial_data,
  // outputs
  input wire logic [CHANNELS*CODE_W-1:0] dac_output,
  input wire logic [CHANNELS*CODE_W-1:0] data_register,
  input wire logic [CHANNELS-1:0]        channel_power_down,
  input wire logic [CHANNELS*2-1:0]      channel_termination,
  input wire logic                       bias_enable,
  input wire logic                       write_through_mode,
  input wire logic                       frame_done
);
  // --------
  // checks
  // --------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_reset_clear: assert property ($fell(reset) |-> dac_output == '0 && data_register == '0)
    else $error("reset did not clear codes");
  a_mode_reset: assert property ($fell(reset) |-> !write_through_mode && channel_power_down == '0)
    else $error("bad mode after reset");
  a_bias_follow: assert property (!$past(reset) |-> bias_enable == !(&$past(channel_power_down)))
    else $error("bias does not follow flags");
  a_out_done: assert property ($changed(dac_output) |-> frame_done)
    else $error("output moved without a frame");
  a_mode_done: assert property ($changed(write_through_mode) |-> frame_done)
    else $error("mode moved without a frame");
  a_pd_keeps: assert property ((channel_power_down & ~$past(channel_power_down)) != '0 |-> $stable(data_register))
    else $error("power-down altered registers");
  a_term_done: assert property ($changed(channel_termination) |-> frame_done)
    else $error("termination moved without a frame");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("done longer than one cycle");
  a_select_quiet: assert property (!frame_sel_n [*5] |-> !frame_done)
    else $error("done while select low");
  cover property (frame_done && write_through_mode);
  cover property (&channel_power_down);
  cover property ($rose(bias_enable));
endmodule
bind octal_dac_command_decoder dac_cmd_properties #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_dac_cmd_properties (
  .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .frame_sel_n(frame_sel_n), .serial_data(serial_data),
  .dac_output(dac_output), .data_register(data_register), .channel_power_down(channel_power_down),
  .channel_termination(channel_termination), .bias_enable(bias_enable),
  .write_through_mode(write_through_mode), .frame_done(frame_done));

// >>> verif/host_link_model.sv
// host model: drives frames on the three wire link
`timescale 1ns/1ps
module host_link_model (
  // link pins
  output logic link_clk,
  output logic frame_sel_n,
  output logic serial_data
);
  // --------
  // frame driver
  // --------
  // clock stands still between frames; data idles low to save power
  initial begin
    link_clk = 1'b0;
    frame_sel_n = 1'b1;
    serial_data = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    logic [31:0] s;
    s = {~w, w};
    #7 frame_sel_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      #2 serial_data = s[n-1-k];
      #13 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
    #10 frame_sel_n = 1'b1;
    serial_data = 1'b0;
  endtask
endmodule

// >>> verif/testbench.sv
// testbench: self-checking run of the dac command decoder
`timescale 1ns/1ps
module testbench;
  import dac_cmd_pkg::*;
  logic        sys_clk, reset, link_clk, frame_sel_n, serial_data;
  logic        bias_enable, write_through_mode, frame_done;
  logic [79:0] dac_output, data_register;
  logic [7:0]  channel_power_down, epd;
  logic [15:0] channel_termination;
  logic [9:0]  eo[8], er[8];
  logic [1:0]  et[8];
  logic        em;
  int          errors, compares;
  integer      seed;
  octal_dac_command_decoder u_octal_dac_command_decoder (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
    .frame_sel_n(frame_sel_n), .serial_data(serial_data), .dac_output(dac_output), .data_register(data_register),
    .channel_power_down(channel_power_down), .channel_termination(channel_termination), .bias_enable(bias_enable),
    .write_through_mode(write_through_mode), .frame_done(frame_done));
  host_link_model u_host_link_model (.link_clk(link_clk), .frame_sel_n(frame_sel_n), .serial_data(serial_data));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // --------
  // expectation model
  // --------
  function void model(input logic [15:0] w);
    logic [9:0] c;
    c = w[CODE_HI:CODE_LO];
    if (!w[15]) begin
      er[w[ADDR_HI:ADDR_LO]] = c;
      if (em) eo[w[ADDR_HI:ADDR_LO]] = c;
      if (em) epd[w[ADDR_HI:ADDR_LO]] = 1'b0;
    end else for (int i = 0; i < 8; i++) begin
      case (w[NIB_HI:NIB_LO])
        CMD_REG_ONLY: em = 1'b0;
        CMD_WRITE_THRU: em = 1'b1;
        CMD_UPDATE_SEL: if (w[i]) begin
          eo[i] = er[i];
          epd[i] = 1'b0;
        end
        CMD_CHA_WRITE: begin
          if (i == 0) er[0] = c;
          eo[i] = er[i];
          epd[i] = 1'b0;
        end
        CMD_BROADCAST: begin
          er[i] = c;
          eo[i] = c;
          epd[i] = 1'b0;
        end
        default: if (w[i]) begin
          epd[i] = 1'b1;
          et[i] = w[13:12] - 2'h1;
        end
      endcase
    end
  endfunction
  task chk(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task check_all();
    for (int i = 0; i < 8; i++) begin
      chk("output", eo[i], dac_output[i*10+:10]);
      chk("register", er[i], data_register[i*10+:10]);
      chk("termination", 10'(et[i]), 10'(channel_termination[i*2+:2]));
    end
    chk("power_down", 10'(epd), 10'(channel_power_down));
    chk("bias", 10'(~&epd), 10'(bias_enable));
    chk("mode", 10'(em), 10'(write_through_mode));
  endtask
  task frame(input logic [15:0] w, input int n);
    logic seen;
    seen = 1'b0;
    u_host_link_model.send(w, n);
    repeat (12) begin
      @(posedge sys_clk);
      #1 seen = seen | (frame_done === 1'b1);
    end
    chk("frame_done", 10'(n > 14), 10'(seen));
    if (n > 14) model(w);
    check_all();
  endtask
  task do_reset(input int n);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) {eo[i], er[i], et[i]} = '0;
    epd = '0;
    em = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check_all();
  endtask
  task results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    results();
  end
  // --------
  // scenarios
  // --------
  initial begin
    seed = 32'h98f32aaf;
    errors = 0;
    compares = 0;
    reset = 1'b1;
    do_reset(8);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) frame({1'b0, 3'(i), 12'($random(seed))}, 16);
      frame({CMD_CHA_WRITE, 12'($random(seed))}, 16);
      frame({CMD_UPDATE_SEL, 12'($random(seed))}, 16);
      frame({CMD_BROADCAST, 12'($random(seed))}, 16);
      frame(16'h2ABC, 14);
      frame({CMD_WRITE_THRU, 12'($random(seed))}, 16);
    end
    for (int c = 13; c < 16; c++) frame({4'(c), 12'($random(seed))}, 16);
    frame({CMD_PD_2K5, 12'h0FF}, 16);
    frame(16'h5FFC, 16);
    frame({CMD_UPDATE_SEL, 12'h003}, 16);
    frame({CMD_REG_ONLY, 12'hFFF}, 16);
    frame(16'h6800, 16);
    repeat (40) frame(16'($random(seed)), 16);
    do_reset(3);
    frame({CMD_BROADCAST, 12'hFFF}, 16);
    results();
  end
endmodule
